//--- rtl/banked_register_state_map.sv
`timescale 1ns/1ps
`default_nettype none
module banked_register_state_map import bank_state_pkg::*; #(
  parameter logic [1:0] ENDIAN_MODE = ENDIAN_BOTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // current processor state
  input wire logic [1:0] cur_el,
  input wire logic cur_arch32,
  input wire mode_t cur_mode,
  // system register moves
  input wire logic sr_valid,
  input wire logic sr_write,
  input wire sreg_t sr_sel,
  input wire logic [63:0] sr_wdata,
  output logic [63:0] sr_rdata,
  output logic sr_ack,
  output logic sr_denied,
  // general register port
  input wire gpr_req_t gpr_req,
  output logic [63:0] gpr_rdata,
  output logic gpr_ack,
  // exception entry
  input wire exc_req_t exc,
  // instruction checks
  input wire logic ins_valid,
  input wire logic ins_is_it,
  input wire logic ins_is_endian_switch_instruction,
  input wire logic ins_is_barrier,
  input wire logic ins_is_short,
  output logic undef_take,
  output logic it_as_short,
  output logic it_follow_err,
  // control outputs
  output ctl_out_t ctl_out
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic sr_ok(sreg_t s, logic [1:0] el, logic a32);
    logic [1:0] need;
    case (s)
      SR_CTL2, SR_SPSR2, SR_ELR2, SR_SP1: need = 2'h2;
      SR_CTL3, SR_SPSR3, SR_ELR3, SR_SP2: need = 2'h3;
      SR_SAVED_STATUS_REGISTER_ABT, SR_SAVED_STATUS_REGISTER_UND, SR_SAVED_STATUS_REGISTER_IRQ, SR_SAVED_STATUS_REGISTER_FIQ:
        need = a32 ? 2'h1 : 2'h2;
      default: need = 2'h1;
    endcase
    return el >= need;
  endfunction : sr_ok

  function automatic sreg_t saved_status_register_of(mode_t m);
    case (m)
      M_SVC: return SR_SPSR1;
      M_HYP: return SR_SPSR2;
      M_MON: return SR_SPSR3;
      M_ABT: return SR_SAVED_STATUS_REGISTER_ABT;
      M_UND: return SR_SAVED_STATUS_REGISTER_UND;
      M_IRQ: return SR_SAVED_STATUS_REGISTER_IRQ;
      M_FIQ: return SR_SAVED_STATUS_REGISTER_FIQ;
      default: return SR_SPSR1;
    endcase
  endfunction : saved_status_register_of

  function automatic logic [63:0] fix_endian(logic [63:0] v);
    logic [63:0] r;
    r = v;
    if (ENDIAN_MODE == ENDIAN_LITTLE) begin
      r[BIT_EE] = 1'b0;
      r[BIT_E0E] = 1'b0;
    end else if (ENDIAN_MODE == ENDIAN_BIG) begin
      r[BIT_EE] = 1'b1;
      r[BIT_E0E] = 1'b1;
    end
    return r;
  endfunction : fix_endian

  function automatic sreg_t ctl_of(logic [1:0] el);
    case (el)
      2'h2: return SR_CTL2;
      2'h3: return SR_CTL3;
      default: return SR_CTL1;
    endcase
  endfunction : ctl_of

  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  localparam logic [63:0] ONE64 = 64'h0000_0000_0000_0001;
  localparam logic [63:0] ENDIAN_BITS =
    (ONE64 << BIT_EE) | (ONE64 << BIT_E0E);
  localparam logic [63:0] CTL_INIT =
    (ENDIAN_MODE == ENDIAN_BIG) ? (CTL_RESET | ENDIAN_BITS) :
    (ENDIAN_MODE == ENDIAN_LITTLE) ? (CTL_RESET & ~ENDIAN_BITS) : CTL_RESET;
  logic [63:0] xr_r [NUM_X];
  logic [63:0] xr_nxt [NUM_X];
  logic [63:0] sr_r [NUM_SR];
  logic [63:0] sr_nxt [NUM_SR];
  logic [63:0] sr_rdata_r, sr_rdata_nxt;
  logic sr_ack_r, sr_ack_nxt;
  logic sr_denied_r, sr_denied_nxt;
  logic [63:0] gpr_rdata_r, gpr_rdata_nxt;
  logic gpr_ack_r, gpr_ack_nxt;
  logic undef_r, undef_nxt;
  logic it_short_r, it_short_nxt;
  logic it_err_r, it_err_nxt;
  logic it_pend_r, it_pend_nxt;
  ctl_out_t ctl_r, ctl_nxt;
  logic [4:0] gpr_phys, lr_phys;
  logic [63:0] ctl_cur, ctl_lvl1;
  logic a32_ins;

  bank_map u_gpr_map (
    .mode(cur_mode),
    .idx(gpr_req.idx[3:0]),
    .phys(gpr_phys)
  );

  bank_map u_lr_map (
    .mode(exc.to_mode),
    .idx(R_LR),
    .phys(lr_phys)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [4:0] gi;
    logic ok;
    gi = 5'h00;
    ok = 1'b0;
    xr_nxt = xr_r;
    sr_nxt = sr_r;
    sr_rdata_nxt = sr_rdata_r;
    sr_ack_nxt = 1'b0;
    sr_denied_nxt = 1'b0;
    gpr_rdata_nxt = gpr_rdata_r;
    gpr_ack_nxt = 1'b0;
    // register port, banked selection by mode in 32-bit state, direct index otherwise
    gi = cur_arch32 ? gpr_phys : gpr_req.idx;
    if (gpr_req.valid && gi < 5'(NUM_X)) begin
      gpr_ack_nxt = 1'b1;
      if (cur_arch32) begin
        gpr_rdata_nxt = {UPPER_ZERO, xr_r[gi][31:0]};
        if (gpr_req.write) begin
          xr_nxt[gi][31:0] = gpr_req.wdata[31:0];
        end
      end else begin
        gpr_rdata_nxt = xr_r[gi];
        if (gpr_req.write) begin
          xr_nxt[gi] = gpr_req.wdata;
        end
      end
    end else if (gpr_req.valid) begin
      gpr_ack_nxt = 1'b1;
      gpr_rdata_nxt = REG_RESET;
    end
    // system register moves
    if (sr_valid) begin
      ok = sr_ok(sr_sel, cur_el, cur_arch32);
      sr_ack_nxt = 1'b1;
      sr_denied_nxt = !ok;
      sr_rdata_nxt = ok ? sr_r[sr_sel] : REG_RESET;
      if (ok && sr_write) begin
        case (sr_sel)
          SR_CTL1, SR_CTL2, SR_CTL3:
            sr_nxt[sr_sel] = fix_endian(sr_wdata);
          SR_SPSR1, SR_SPSR2, SR_SPSR3, SR_SAVED_STATUS_REGISTER_ABT,
          SR_SAVED_STATUS_REGISTER_UND, SR_SAVED_STATUS_REGISTER_IRQ, SR_SAVED_STATUS_REGISTER_FIQ:
            sr_nxt[sr_sel] = {UPPER_ZERO, sr_wdata[31:0]};
          default: sr_nxt[sr_sel] = sr_wdata;
        endcase
      end
    end
    // exception entry wins over same-cycle moves
    if (exc.valid) begin
      if (exc.to_arch32) begin
        sr_nxt[saved_status_register_of(exc.to_mode)] = {UPPER_ZERO, exc.status};
        if (exc.to_mode == M_HYP) begin
          sr_nxt[SR_ELR2] = {UPPER_ZERO, exc.ret_addr[31:0]};
        end else begin
          xr_nxt[lr_phys][31:0] = exc.ret_addr[31:0];
        end
      end else begin
        case (exc.to_el)
          2'h2: begin
            sr_nxt[SR_SPSR2] = {UPPER_ZERO, exc.status};
            sr_nxt[SR_ELR2] = exc.from_arch32 ?
              {UPPER_ZERO, exc.ret_addr[31:0]} : exc.ret_addr;
          end
          2'h3: begin
            sr_nxt[SR_SPSR3] = {UPPER_ZERO, exc.status};
            sr_nxt[SR_ELR3] = exc.from_arch32 ?
              {UPPER_ZERO, exc.ret_addr[31:0]} : exc.ret_addr;
            // level-2 link upper half left as held
          end
          default: begin
            sr_nxt[SR_SPSR1] = {UPPER_ZERO, exc.status};
            sr_nxt[SR_ELR1] = exc.from_arch32 ?
              {UPPER_ZERO, exc.ret_addr[31:0]} : exc.ret_addr;
          end
        endcase
      end
    end
  end

  // control view derived from the next register values
  always_comb begin
    ctl_lvl1 = sr_nxt[SR_CTL1];
    ctl_cur = sr_nxt[ctl_of(cur_el)];
    ctl_nxt.dcache_en = ctl_cur[BIT_DCACHE];
    ctl_nxt.icache_en = ctl_cur[BIT_ICACHE];
    ctl_nxt.mmu_en = ctl_cur[BIT_MMU];
    ctl_nxt.align_chk = ctl_cur[BIT_ALIGN];
    ctl_nxt.stack_chk = (cur_el == 2'h0) ?
      ctl_lvl1[BIT_STACK0] : ctl_cur[BIT_STACK];
    ctl_nxt.barrier_en = ctl_cur[BIT_BARRIER];
    ctl_nxt.it_disable = ctl_cur[BIT_ITD];
    ctl_nxt.data_big_endian = (cur_el == 2'h0) ?
      ctl_lvl1[BIT_E0E] : ctl_cur[BIT_EE];
    ctl_nxt.fetch_big_endian = 1'b0;
  end

  // ----------------------------------------
  // instruction checks
  // ----------------------------------------
  always_comb begin
    a32_ins = ins_valid && cur_arch32;
    undef_nxt = 1'b0;
    it_short_nxt = 1'b0;
    it_err_nxt = 1'b0;
    it_pend_nxt = it_pend_r;
    if (a32_ins) begin
      if (ins_is_endian_switch_instruction && cur_el == 2'h0
          && sr_r[SR_CTL1][BIT_SED]) begin
        undef_nxt = 1'b1;
      end
      if (ins_is_barrier && !ctl_r.barrier_en) begin
        undef_nxt = 1'b1;
      end
      if (it_pend_r && !ins_is_short) begin
        it_err_nxt = 1'b1;
      end
      it_pend_nxt = ins_is_it && ctl_r.it_disable;
      it_short_nxt = ins_is_it && ctl_r.it_disable;
    end else if (ins_valid) begin
      it_pend_nxt = 1'b0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_X; i++) begin
        xr_r[i] <= REG_RESET;
      end
      for (int i = 0; i < NUM_SR; i++) begin
        sr_r[i] <= (i <= int'(SR_CTL3)) ? CTL_INIT : REG_RESET;
      end
      sr_rdata_r <= REG_RESET;
      sr_ack_r <= 1'b0;
      sr_denied_r <= 1'b0;
      gpr_rdata_r <= REG_RESET;
      gpr_ack_r <= 1'b0;
      undef_r <= 1'b0;
      it_short_r <= 1'b0;
      it_err_r <= 1'b0;
      it_pend_r <= 1'b0;
      ctl_r <= '0;
    end else begin
      xr_r <= xr_nxt;
      sr_r <= sr_nxt;
      sr_rdata_r <= sr_rdata_nxt;
      sr_ack_r <= sr_ack_nxt;
      sr_denied_r <= sr_denied_nxt;
      gpr_rdata_r <= gpr_rdata_nxt;
      gpr_ack_r <= gpr_ack_nxt;
      undef_r <= undef_nxt;
      it_short_r <= it_short_nxt;
      it_err_r <= it_err_nxt;
      it_pend_r <= it_pend_nxt;
      ctl_r <= ctl_nxt;
    end
  end

  assign sr_rdata = sr_rdata_r;
  assign sr_ack = sr_ack_r;
  assign sr_denied = sr_denied_r;
  assign gpr_rdata = gpr_rdata_r;
  assign gpr_ack = gpr_ack_r;
  assign undef_take = undef_r;
  assign it_as_short = it_short_r;
  assign it_follow_err = it_err_r;
  assign ctl_out = ctl_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_ENDIAN_SWITCH_INSTRUCTION_UNDEF: assert property (
    ins_valid && cur_arch32 && ins_is_endian_switch_instruction && cur_el == 2'h0
    && sr_r[SR_CTL1][BIT_SED] |=> undef_take)
    else $error("endian switch not refused");
  AST_ENDIAN_SWITCH_INSTRUCTION_OK: assert property (
    ins_valid && ins_is_endian_switch_instruction && !ins_is_barrier
    && !sr_r[SR_CTL1][BIT_SED] |=> !undef_take)
    else $error("endian switch refused while enabled");
  AST_IT_FOLLOW: assert property (
    ins_valid && cur_arch32 && ins_is_it && ctl_out.it_disable
    ##1 ins_valid && cur_arch32 && !ins_is_short |=> it_follow_err)
    else $error("bad follower of short conditional block missed");
  AST_BARRIER: assert property (
    ins_valid && cur_arch32 && ins_is_barrier && !ctl_out.barrier_en
    |=> undef_take)
    else $error("legacy barrier not gated");
  AST_ELR_ZERO: assert property (
    exc.valid && exc.from_arch32 && !exc.to_arch32 && exc.to_el == 2'h1
    |=> sr_r[SR_ELR1][63:32] == UPPER_ZERO)
    else $error("link upper half not zero");
  AST_SAVED_STATUS_REGISTER_COPY: assert property (
    exc.valid && exc.to_arch32 && exc.to_mode == M_IRQ
    |=> sr_r[SR_SAVED_STATUS_REGISTER_IRQ][31:0] == $past(exc.status))
    else $error("status not saved");
  AST_UPPER_HIDDEN: assert property (
    gpr_req.valid && cur_arch32 |=> gpr_rdata[63:32] == UPPER_ZERO)
    else $error("upper half visible in 32-bit state");
  AST_FETCH_LE: assert property (
    !ctl_out.fetch_big_endian)
    else $error("fetch not little-endian");
  AST_ENDIAN_FIX: assert property (
    (ENDIAN_MODE != ENDIAN_LITTLE || !ctl_out.data_big_endian)
    && (ENDIAN_MODE != ENDIAN_BIG
    || (sr_r[SR_CTL1][BIT_EE] && sr_r[SR_CTL1][BIT_E0E])))
    else $error("fixed endianness broken");
  AST_DCACHE: assert property (
    sr_valid && sr_write && sr_sel == SR_CTL1 && cur_el == 2'h1
    && !exc.valid |=> ctl_out.dcache_en == $past(sr_wdata[BIT_DCACHE]))
    else $error("data cache enable not applied");
  AST_SP_KEEP: assert property (
    cur_arch32 && gpr_req.valid && !sr_valid && !exc.valid
    |=> $stable(sr_r[SR_SP1]) && $stable(sr_r[SR_ELR1]))
    else $error("hidden stack pointer changed");
  AST_FIQ_BANK: assert property (
    gpr_req.valid && gpr_req.write && cur_arch32 && cur_mode == M_FIQ
    && gpr_req.idx == 5'h08 && !exc.valid
    |=> xr_r[24][31:0] == $past(gpr_req.wdata[31:0]))
    else $error("fast-interrupt bank mismatch");

  COV_ENDIAN_SWITCH_INSTRUCTION: cover property (undef_take);
  COV_EXC32: cover property (exc.valid && exc.from_arch32 && !exc.to_arch32);
  COV_DENIED: cover property (sr_ack && sr_denied);

endmodule : banked_register_state_map
`default_nettype wire

//--- rtl/bank_state_pkg.sv
package bank_state_pkg;

  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int BIT_MMU = 0;
  localparam int BIT_ALIGN = 1;
  localparam int BIT_DCACHE = 2;
  localparam int BIT_STACK = 3;
  localparam int BIT_STACK0 = 4;
  localparam int BIT_BARRIER = 5;
  localparam int BIT_ITD = 7;
  localparam int BIT_SED = 8;
  localparam int BIT_ICACHE = 12;
  localparam int BIT_E0E = 24;
  localparam int BIT_EE = 25;
  localparam logic [63:0] CTL_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;
  localparam logic [31:0] UPPER_ZERO = 32'h0000_0000;

  // ----------------------------------------
  // endian support
  // ----------------------------------------
  localparam logic [1:0] ENDIAN_BOTH = 2'h0;
  localparam logic [1:0] ENDIAN_LITTLE = 2'h1;
  localparam logic [1:0] ENDIAN_BIG = 2'h2;

  // ----------------------------------------
  // physical register numbers
  // ----------------------------------------
  localparam logic [4:0] X_FIQ_BASE = 5'h18;
  localparam logic [4:0] X_FIQ_SP = 5'h1d;
  localparam logic [4:0] X_FIQ_LR = 5'h1e;
  localparam logic [4:0] X_IRQ_SP = 5'h11;
  localparam logic [4:0] X_IRQ_LR = 5'h10;
  localparam logic [4:0] X_ABT_SP = 5'h15;
  localparam logic [4:0] X_ABT_LR = 5'h14;
  localparam logic [4:0] X_SVC_SP = 5'h13;
  localparam logic [4:0] X_SVC_LR = 5'h12;
  localparam logic [4:0] X_UND_SP = 5'h17;
  localparam logic [4:0] X_UND_LR = 5'h16;
  localparam logic [4:0] X_HYP_SP = 5'h0f;
  localparam logic [3:0] R_FIQ_LO = 4'h8;
  localparam logic [3:0] R_SP = 4'hd;
  localparam logic [3:0] R_LR = 4'he;
  localparam int NUM_X = 31;
  localparam int NUM_SR = 16;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    M_USR, M_SYS, M_FIQ, M_IRQ, M_ABT, M_SVC, M_UND, M_MON, M_HYP
  } mode_t;

  typedef enum logic [3:0] {
    SR_CTL1, SR_CTL2, SR_CTL3, SR_SPSR1, SR_SPSR2, SR_SPSR3,
    SR_SAVED_STATUS_REGISTER_ABT, SR_SAVED_STATUS_REGISTER_UND, SR_SAVED_STATUS_REGISTER_IRQ, SR_SAVED_STATUS_REGISTER_FIQ,
    SR_ELR1, SR_ELR2, SR_ELR3, SR_SP0, SR_SP1, SR_SP2
  } sreg_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] idx;
    logic [63:0] wdata;
  } gpr_req_t;

  typedef struct packed {
    logic valid;
    logic from_arch32;
    logic to_arch32;
    logic [1:0] to_el;
    mode_t to_mode;
    logic [31:0] status;
    logic [63:0] ret_addr;
  } exc_req_t;

  typedef struct packed {
    logic dcache_en;
    logic icache_en;
    logic mmu_en;
    logic align_chk;
    logic stack_chk;
    logic barrier_en;
    logic it_disable;
    logic data_big_endian;
    logic fetch_big_endian;
  } ctl_out_t;

endpackage : bank_state_pkg

//--- rtl/bank_map.sv
`timescale 1ns/1ps
`default_nettype none
module bank_map import bank_state_pkg::*; (
  // selection
  input wire mode_t mode,
  input wire logic [3:0] idx,
  // physical register
  output logic [4:0] phys
);

  always_comb begin
    phys = {1'b0, idx};
    if (mode == M_FIQ && idx >= R_FIQ_LO && idx < R_SP) begin
      phys = X_FIQ_BASE + 5'(idx - R_FIQ_LO);
    end else if (idx == R_SP || idx == R_LR) begin
      case (mode)
        M_FIQ: phys = (idx == R_SP) ? X_FIQ_SP : X_FIQ_LR;
        M_IRQ: phys = (idx == R_SP) ? X_IRQ_SP : X_IRQ_LR;
        M_ABT: phys = (idx == R_SP) ? X_ABT_SP : X_ABT_LR;
        M_SVC: phys = (idx == R_SP) ? X_SVC_SP : X_SVC_LR;
        M_UND: phys = (idx == R_SP) ? X_UND_SP : X_UND_LR;
        M_HYP: phys = (idx == R_SP) ? X_HYP_SP : {1'b0, idx};
        default: phys = {1'b0, idx};
      endcase
    end
  end

endmodule : bank_map
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import bank_state_pkg::*;;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk;
  logic rst;
  logic [1:0] cur_el;
  logic cur_arch32;
  mode_t cur_mode;
  logic sr_valid;
  logic sr_write;
  sreg_t sr_sel;
  logic [63:0] sr_wdata;
  logic [63:0] sr_rdata;
  logic sr_ack;
  logic sr_denied;
  gpr_req_t gpr_req;
  logic [63:0] gpr_rdata;
  logic gpr_ack;
  exc_req_t exc;
  logic ins_valid;
  logic ins_is_it;
  logic ins_is_endian_switch_instruction;
  logic ins_is_barrier;
  logic ins_is_short;
  logic undef_take;
  logic it_as_short;
  logic it_follow_err;
  ctl_out_t ctl_out;
  ctl_out_t ctl_big;
  logic [63:0] rd;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  banked_register_state_map i_banked_register_state_map (
    .clk(clk), .rst(rst), .cur_el(cur_el), .cur_arch32(cur_arch32),
    .cur_mode(cur_mode), .sr_valid(sr_valid), .sr_write(sr_write),
    .sr_sel(sr_sel), .sr_wdata(sr_wdata), .sr_rdata(sr_rdata),
    .sr_ack(sr_ack), .sr_denied(sr_denied), .gpr_req(gpr_req),
    .gpr_rdata(gpr_rdata), .gpr_ack(gpr_ack), .exc(exc),
    .ins_valid(ins_valid), .ins_is_it(ins_is_it),
    .ins_is_endian_switch_instruction(ins_is_endian_switch_instruction), .ins_is_barrier(ins_is_barrier),
    .ins_is_short(ins_is_short), .undef_take(undef_take),
    .it_as_short(it_as_short), .it_follow_err(it_follow_err),
    .ctl_out(ctl_out)
  );

  // big-endian-only variant, same inputs
  banked_register_state_map #(.ENDIAN_MODE(ENDIAN_BIG))
    i_banked_register_state_map_big (
    .clk(clk), .rst(rst), .cur_el(cur_el), .cur_arch32(cur_arch32),
    .cur_mode(cur_mode), .sr_valid(sr_valid), .sr_write(sr_write),
    .sr_sel(sr_sel), .sr_wdata(sr_wdata), .sr_rdata(), .sr_ack(),
    .sr_denied(), .gpr_req(gpr_req), .gpr_rdata(), .gpr_ack(),
    .exc(exc), .ins_valid(ins_valid), .ins_is_it(ins_is_it),
    .ins_is_endian_switch_instruction(ins_is_endian_switch_instruction), .ins_is_barrier(ins_is_barrier),
    .ins_is_short(ins_is_short), .undef_take(), .it_as_short(),
    .it_follow_err(), .ctl_out(ctl_big)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test();
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic st(input logic [1:0] el, input logic a32, input mode_t m);
    @(negedge clk);
    cur_el = el;
    cur_arch32 = a32;
    cur_mode = m;
    @(negedge clk);
    @(negedge clk);
  endtask : st

  task automatic sr_acc(input logic wr, input sreg_t sel,
                        input logic [63:0] wd, input logic den,
                        input logic [63:0] exp);
    @(negedge clk);
    sr_valid = 1'b1;
    sr_write = wr;
    sr_sel = sel;
    sr_wdata = wd;
    @(negedge clk);
    chk("sr_ack", 1, sr_ack);
    chk("sr_denied", den, sr_denied);
    if (!wr || den) chk("sr_rdata", exp, sr_rdata);
    sr_valid = 1'b0;
  endtask : sr_acc

  task automatic gpr_acc(input logic wr, input logic [4:0] idx,
                         input logic [63:0] wd, output logic [63:0] q);
    @(negedge clk);
    gpr_req.valid = 1'b1;
    gpr_req.write = wr;
    gpr_req.idx = idx;
    gpr_req.wdata = wd;
    @(negedge clk);
    chk("gpr_ack", 1, gpr_ack);
    q = gpr_rdata;
    gpr_req.valid = 1'b0;
  endtask : gpr_acc

  task automatic exc_go(input logic f32, input logic t32,
                        input logic [1:0] el, input mode_t m,
                        input logic [31:0] stat, input logic [63:0] ret);
    @(negedge clk);
    exc.valid = 1'b1;
    exc.from_arch32 = f32;
    exc.to_arch32 = t32;
    exc.to_el = el;
    exc.to_mode = m;
    exc.status = stat;
    exc.ret_addr = ret;
    @(negedge clk);
    exc.valid = 1'b0;
  endtask : exc_go

  task automatic ins_chk(input logic it, input logic se, input logic bar,
                         input logic sh, input logic [2:0] exp);
    @(negedge clk);
    ins_valid = 1'b1;
    ins_is_it = it;
    ins_is_endian_switch_instruction = se;
    ins_is_barrier = bar;
    ins_is_short = sh;
    @(negedge clk);
    chk("ins_flags", exp, {undef_take, it_as_short, it_follow_err});
    ins_valid = 1'b0;
  endtask : ins_chk

  function automatic logic [4:0] pmap(input mode_t m, input int r);
    if (r < 8) return 5'(r);
    if (m == M_FIQ) return 5'(r + 16);
    if (r < 13) return 5'(r);
    case (m)
      M_IRQ: return (r == 13) ? 5'h11 : 5'h10;
      M_ABT: return (r == 13) ? 5'h15 : 5'h14;
      M_SVC: return (r == 13) ? 5'h13 : 5'h12;
      M_UND: return (r == 13) ? 5'h17 : 5'h16;
      M_HYP: return (r == 13) ? 5'h0f : 5'h0e;
      default: return 5'(r);
    endcase
  endfunction : pmap

  function automatic logic [63:0] pat(input int i);
    return {32'hA5A5_0000 + 32'(i), 32'h1234_0000 + 32'(i)};
  endfunction : pat

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_ctl();
    st(2'h1, 1'b0, M_USR);
    sr_acc(1'b0, SR_CTL1, 0, 1'b0, 0);
    chk("ctl_reset", 0, ctl_out);
    sr_acc(1'b1, SR_CTL1, 64'h0000_0000_0000_100F, 1'b0, 0);
    sr_acc(1'b0, SR_CTL1, 0, 1'b0, 64'h0000_0000_0000_100F);
    @(negedge clk);
    chk("ctl_el1", 5'h1F, {ctl_out.dcache_en, ctl_out.icache_en,
        ctl_out.mmu_en, ctl_out.align_chk, ctl_out.stack_chk});
    st(2'h0, 1'b0, M_USR);
    chk("ctl_el0", 5'h1E, {ctl_out.dcache_en, ctl_out.icache_en,
        ctl_out.mmu_en, ctl_out.align_chk, ctl_out.stack_chk});
  endtask : t_ctl

  task automatic t_endian();
    st(2'h1, 1'b0, M_USR);
    sr_acc(1'b1, SR_CTL1, 64'h0000_0000_0200_0000, 1'b0, 0);
    @(negedge clk);
    chk("end_el1", 2'h2, {ctl_out.data_big_endian,
        ctl_out.fetch_big_endian});
    chk("big_el1", 2'h2, {ctl_big.data_big_endian,
        ctl_big.fetch_big_endian});
    st(2'h0, 1'b0, M_USR);
    chk("end_el0", 2'h0, {ctl_out.data_big_endian,
        ctl_out.fetch_big_endian});
    chk("big_el0", 2'h2, {ctl_big.data_big_endian,
        ctl_big.fetch_big_endian});
    st(2'h1, 1'b0, M_USR);
    sr_acc(1'b1, SR_CTL1, 64'h0000_0000_0100_0000, 1'b0, 0);
    @(negedge clk);
    chk("e0_el1", 2'h0, {ctl_out.data_big_endian,
        ctl_out.fetch_big_endian});
    st(2'h0, 1'b0, M_USR);
    chk("e0_el0", 2'h2, {ctl_out.data_big_endian,
        ctl_out.fetch_big_endian});
    st(2'h2, 1'b0, M_USR);
    sr_acc(1'b1, SR_CTL2, 64'h0000_0000_0200_0000, 1'b0, 0);
    @(negedge clk);
    chk("end_el2", 2'h2, {ctl_out.data_big_endian,
        ctl_out.fetch_big_endian});
  endtask : t_endian

  task automatic t_bank();
    mode_t ml[7] = '{M_USR, M_FIQ, M_IRQ, M_ABT, M_SVC, M_UND, M_HYP};
    int rl[5] = '{0, 8, 12, 13, 14};
    logic [63:0] q;
    st(2'h1, 1'b0, M_USR);
    for (int i = 0; i < 31; i++) gpr_acc(1'b1, 5'(i), pat(i), q);
    foreach (ml[m]) begin
      st(2'h1, 1'b1, ml[m]);
      foreach (rl[r]) begin
        gpr_acc(1'b0, 5'(rl[r]), 0, q);
        chk("gpr32", pat(pmap(ml[m], rl[r])) & 64'h0000_0000_FFFF_FFFF,
            q);
      end
    end
    st(2'h1, 1'b1, M_FIQ);
    gpr_acc(1'b1, 5'h08, 64'hFFFF_FFFF_DEAD_BEEF, q);
    st(2'h1, 1'b0, M_USR);
    gpr_acc(1'b0, 5'h18, 0, q);
    chk("x24", 64'hA5A5_0018_DEAD_BEEF, q);
    gpr_acc(1'b0, 5'h08, 0, q);
    chk("x8", pat(8), q);
  endtask : t_bank

  task automatic t_exc();
    st(2'h1, 1'b0, M_USR);
    sr_acc(1'b1, SR_SP0, 64'h0123_4567_89AB_CDEF, 1'b0, 0);
    exc_go(1'b1, 1'b0, 2'h1, M_USR, 32'h0000_01D3,
           64'hFFFF_FFFF_8000_0040);
    sr_acc(1'b0, SR_ELR1, 0, 1'b0, 64'h0000_0000_8000_0040);
    sr_acc(1'b0, SR_SPSR1, 0, 1'b0, 64'h0000_0000_0000_01D3);
    exc_go(1'b0, 1'b1, 2'h1, M_IRQ, 32'h0000_0012,
           64'hFFFF_FFFF_1000_0004);
    exc_go(1'b0, 1'b1, 2'h2, M_HYP, 32'h0000_001A,
           64'hFFFF_FFFF_2000_0008);
    exc_go(1'b0, 1'b1, 2'h1, M_SVC, 32'h0000_0013, 0);
    sr_acc(1'b0, SR_SAVED_STATUS_REGISTER_ABT, 0, 1'b1, 0);
    st(2'h2, 1'b0, M_USR);
    sr_acc(1'b0, SR_SAVED_STATUS_REGISTER_IRQ, 0, 1'b0, 64'h0000_0000_0000_0012);
    sr_acc(1'b0, SR_SPSR2, 0, 1'b0, 64'h0000_0000_0000_001A);
    sr_acc(1'b0, SR_ELR2, 0, 1'b0, 64'h0000_0000_2000_0008);
    sr_acc(1'b0, SR_SPSR1, 0, 1'b0, 64'h0000_0000_0000_0013);
    sr_acc(1'b0, SR_SP0, 0, 1'b0, 64'h0123_4567_89AB_CDEF);
    gpr_acc(1'b0, 5'h10, 0, rd);
    chk("lr_irq", 64'h1000_0004, rd & 64'h0000_0000_FFFF_FFFF);
    st(2'h3, 1'b0, M_USR);
    exc_go(1'b1, 1'b0, 2'h3, M_USR, 32'h0000_01DA, 64'hFFFF_FFFF_3000_000C);
    sr_acc(1'b0, SR_ELR3, 0, 1'b0, 64'h0000_0000_3000_000C);
    sr_acc(1'b0, SR_ELR2, 0, 1'b0, 64'h0000_0000_2000_0008);
  endtask : t_exc

  task automatic t_ins();
    st(2'h1, 1'b0, M_USR);
    sr_acc(1'b1, SR_CTL1, 64'h0000_0000_0000_01A0, 1'b0, 0);
    st(2'h0, 1'b1, M_USR);
    ins_chk(1'b0, 1'b1, 1'b0, 1'b0, 3'h4);
    ins_chk(1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
    ins_chk(1'b1, 1'b0, 1'b0, 1'b1, 3'h2);
    ins_chk(1'b0, 1'b0, 1'b0, 1'b0, 3'h1);
    ins_chk(1'b1, 1'b0, 1'b0, 1'b1, 3'h2);
    ins_chk(1'b0, 1'b0, 1'b0, 1'b1, 3'h0);
    st(2'h1, 1'b1, M_SVC);
    ins_chk(1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
    st(2'h1, 1'b0, M_USR);
    sr_acc(1'b1, SR_CTL1, 0, 1'b0, 0);
    st(2'h0, 1'b1, M_USR);
    ins_chk(1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
    ins_chk(1'b0, 1'b0, 1'b1, 1'b0, 3'h4);
    ins_chk(1'b1, 1'b0, 1'b0, 1'b1, 3'h0);
  endtask : t_ins

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    cur_el = 2'h0;
    cur_arch32 = 1'b0;
    cur_mode = M_USR;
    sr_valid = 1'b0;
    sr_write = 1'b0;
    sr_sel = SR_CTL1;
    sr_wdata = 64'h0000_0000_0000_0000;
    gpr_req = '0;
    exc = '0;
    ins_valid = 1'b0;
    ins_is_it = 1'b0;
    ins_is_endian_switch_instruction = 1'b0;
    ins_is_barrier = 1'b0;
    ins_is_short = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_ctl();
    t_endian();
    t_bank();
    t_exc();
    t_ins();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
